//--- logic/exec_unit_defines.vh
// Opcode field encodings and status bit positions for the execute slice
`ifndef EXEC_UNIT_DEFINES_VH
`define EXEC_UNIT_DEFINES_VH
`define OP_NONE          3'h0
`define OP_ROT_RIGHT     3'h1
`define OP_ROT_LEFT      3'h2
`define OP_LIT_MINUS_ACC 3'h3
`define OP_RETURN_CONST  3'h4
`define OP_SLEEP         3'h5
`define OP_ADD_ACC_PC    3'h6
`define STAT_CARRY       0
`define STAT_NIBBLE      1
`define STAT_ZERO        2
`define STAT_SLEEP_N     3
`define STAT_EXPIRY_N    4
`define STATUS_RESET     5'h18
`define RETURN_CYCLES    2'h2
`endif

//--- logic/literal_sub.v
// Literal minus accumulator with carry, nibble carry and zero
`timescale 1ns/1ps
module literal_sub (
    input  wire [7:0] literal,
    input  wire [7:0] acc,
    output wire [7:0] result,
    output wire       carry,
    output wire       nibble_carry,
    output wire       zero
);
    wire [8:0] diff;
    wire [4:0] low_diff;
    // Borrow-free extra bit means acc <= literal
    assign diff         = {1'b0, literal} - {1'b0, acc};
    assign low_diff     = {1'b0, literal[3:0]} - {1'b0, acc[3:0]};
    assign result       = diff[7:0];
    assign carry        = ~diff[8];
    assign nibble_carry = ~low_diff[4];
    assign zero         = (diff[7:0] == 8'h00);
endmodule

//--- logic/exec_unit.v
// Execute slice: rotates, literal subtract, return with constant, sleep
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "exec_unit_defines.vh"
module exec_unit (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        issue,
    input  wire [2:0]  opcode,
    input  wire [6:0]  file_addr,
    input  wire        dest_file,
    input  wire [7:0]  literal,
    input  wire [7:0]  file_rdata,
    input  wire [10:0] pc_in,
    input  wire [10:0] stack_top,
    input  wire        wake,
    output reg  [7:0]  acc,
    output reg  [4:0]  status,
    output reg         file_we,
    output reg  [6:0]  file_waddr,
    output reg  [7:0]  file_wdata,
    output reg         pc_load,
    output reg  [10:0] pc_value,
    output reg         stack_pop,
    output reg         wdt_clear,
    output reg         osc_stop,
    output wire        busy
);
    localparam RUN    = 2'h0;
    localparam WAIT   = 2'h1;
    localparam ASLEEP = 2'h2;

    reg  [1:0] state;
    reg  [1:0] next_state;
    reg  [1:0] wait_cnt;
    reg  [1:0] next_wait_cnt;
    reg        wake_meta;
    reg        wake_sync;
    wire [7:0] sub_result;
    wire       sub_carry;
    wire       sub_nibble;
    wire       sub_zero;
    wire        accept;
    wire [11:0] table_sum;

    literal_sub u_sub (
        .literal      (literal),
        .acc          (acc),
        .result       (sub_result),
        .carry        (sub_carry),
        .nibble_carry (sub_nibble),
        .zero         (sub_zero)
    );

    // Result goes to the file or the accumulator by the destination bit
    function [8:0] rotate;
        input       left;
        input [7:0] val;
        input       cin;
        begin
            if (left)
                rotate = {val[7], val[6:0], cin};
            else
                rotate = {val[0], cin, val[7:1]};
        end
    endfunction

    reg [8:0] rot;
    always @* begin
        rot = rotate(opcode == `OP_ROT_LEFT, file_rdata, status[`STAT_CARRY]);
    end

    // Opcode decodes shared by the sequencer and the datapath blocks
    function is_rotate;
        input [2:0] op;
        begin
            is_rotate = (op == `OP_ROT_RIGHT) || (op == `OP_ROT_LEFT);
        end
    endfunction

    function is_two_cycle;
        input [2:0] op;
        begin
            is_two_cycle = (op == `OP_RETURN_CONST);
        end
    endfunction

    function is_sleep;
        input [2:0] op;
        begin
            is_sleep = (op == `OP_SLEEP);
        end
    endfunction

    // Busy covers the issuing cycle of a return so the core holds its next fetch
    assign busy   = (state != RUN) | (issue & is_two_cycle(opcode));
    assign accept = issue & (state == RUN);
    // Spare top bit keeps the sum honest; the jump wraps within program memory
    assign table_sum = {1'b0, pc_in} + {4'h0, acc};

    // Wake is an asynchronous event; synchronise before use
    always @(posedge sys_clk) begin
        wake_meta <= wake;
        wake_sync <= wake_meta;
    end

    always @* begin
        next_state    = state;
        next_wait_cnt = wait_cnt;
        case (state)
            RUN: begin
                if (accept && is_two_cycle(opcode)) begin
                    next_state    = WAIT;
                    next_wait_cnt = `RETURN_CYCLES - 2'h1;
                end else if (accept && is_sleep(opcode)) begin
                    next_state = ASLEEP;
                end
            end
            WAIT: begin
                // Second cycle of a two-cycle return; new issues ignored
                next_wait_cnt = wait_cnt - 2'h1;
                if (wait_cnt == 2'h1)
                    next_state = RUN;
            end
            ASLEEP: begin
                // Halted until an external wake; issues are ignored
                if (wake_sync)
                    next_state = RUN;
            end
            default: next_state = RUN;
        endcase
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            state    <= RUN;
            wait_cnt <= 2'h0;
        end else begin
            state    <= next_state;
            wait_cnt <= next_wait_cnt;
        end
    end

    // Each opcode touches only the flags it names; the rest hold
    always @(posedge sys_clk) begin
        if (reset) begin
            acc    <= 8'h00;
            status <= `STATUS_RESET;
        end else if (accept) begin
            if (is_rotate(opcode)) begin
                status[`STAT_CARRY] <= rot[8];
                if (!dest_file)
                    acc <= rot[7:0];
            end else begin
                case (opcode)
                    `OP_LIT_MINUS_ACC: begin
                        acc                  <= sub_result;
                        status[`STAT_CARRY]  <= sub_carry;
                        status[`STAT_NIBBLE] <= sub_nibble;
                        status[`STAT_ZERO]   <= sub_zero;
                    end
                    `OP_RETURN_CONST: begin
                        acc <= literal;
                    end
                    `OP_SLEEP: begin
                        status[`STAT_SLEEP_N]  <= 1'b0;
                        status[`STAT_EXPIRY_N] <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // File write port; address and data hold after the strobe drops
    always @(posedge sys_clk) begin
        if (reset) begin
            file_we    <= 1'b0;
            file_waddr <= 7'h00;
            file_wdata <= 8'h00;
        end else begin
            file_we <= accept & is_rotate(opcode) & dest_file;
            if (accept && is_rotate(opcode) && dest_file) begin
                file_waddr <= file_addr;
                file_wdata <= rot[7:0];
            end
        end
    end

    // Program counter and stack requests to the fetch side
    always @(posedge sys_clk) begin
        if (reset) begin
            pc_load   <= 1'b0;
            pc_value  <= 11'h000;
            stack_pop <= 1'b0;
        end else begin
            pc_load   <= 1'b0;
            stack_pop <= 1'b0;
            if (accept) begin
                case (opcode)
                    `OP_RETURN_CONST: begin
                        stack_pop <= 1'b1;
                        pc_load   <= 1'b1;
                        pc_value  <= stack_top;
                    end
                    `OP_ADD_ACC_PC: begin
                        // Computed jump into the constant table
                        pc_load  <= 1'b1;
                        pc_value <= table_sum[10:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Oscillator stays stopped until the synchronised wake is seen
    always @(posedge sys_clk) begin
        if (reset) begin
            wdt_clear <= 1'b0;
            osc_stop  <= 1'b0;
        end else begin
            wdt_clear <= accept & is_sleep(opcode);
            if (accept && is_sleep(opcode))
                osc_stop <= 1'b1;
            else if ((state == ASLEEP) && wake_sync)
                osc_stop <= 1'b0;
        end
    end
endmodule

//--- sim/exec_unit_properties.sv
// Port level timing checks for the execute slice
`timescale 1ns/1ps
`include "exec_unit_defines.vh"
module exec_unit_properties (
    input wire        sys_clk,
    input wire        reset,
    input wire        issue,
    input wire        dest_file,
    input wire        busy,
    input wire        file_we,
    input wire        pc_load,
    input wire        stack_pop,
    input wire        wdt_clear,
    input wire        osc_stop,
    input wire [2:0]  opcode,
    input wire [7:0]  literal,
    input wire [7:0]  file_rdata,
    input wire [7:0]  acc,
    input wire [7:0]  file_wdata,
    input wire [10:0] pc_in,
    input wire [10:0] stack_top,
    input wire [10:0] pc_value,
    input wire [4:0]  status
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Refused while asleep and in the second cycle of a return, which stack_pop marks
    wire go = issue && !osc_stop && !stack_pop;
    property p_busy; busy == (osc_stop || stack_pop || issue && opcode == `OP_RETURN_CONST);
        endproperty
    a_busy: assert property (p_busy) else $error("busy flag wrong");
    property p_rot_acc; go && opcode == `OP_ROT_RIGHT && !dest_file |=> status[0] ==
        $past(file_rdata[0]) && acc == {$past(status[0]), $past(file_rdata[7:1])}; endproperty
    a_rot_acc: assert property (p_rot_acc) else $error("rotate right to acc wrong");
    property p_rot_file; go && opcode == `OP_ROT_RIGHT && dest_file |=> file_we && acc ==
        $past(acc) && file_wdata == {$past(status[0]), $past(file_rdata[7:1])}; endproperty
    a_rot_file: assert property (p_rot_file) else $error("rotate right to file wrong");
    property p_rot_left; go && opcode == `OP_ROT_LEFT && !dest_file |=>
        acc == {$past(file_rdata[6:0]), $past(status[0])}; endproperty
    a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");
    property p_sub; go && opcode == `OP_LIT_MINUS_ACC |=> acc == $past(literal) - $past(acc)
        && status[0] == ($past(acc) <= $past(literal)) && status[2] == (acc == 8'h00)
        && status[1] == ($past(acc[3:0]) <= $past(literal[3:0])); endproperty
    a_sub: assert property (p_sub) else $error("literal subtract wrong");
    property p_sleep; go && opcode == `OP_SLEEP |=> wdt_clear && status[4:3] == 2'b10
        && status[2:0] == $past(status[2:0]); endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_halt; go && opcode == `OP_SLEEP |=> (osc_stop && busy) [*2]; endproperty
    a_halt: assert property (p_halt) else $error("sleep did not halt");
    property p_ret; go && opcode == `OP_RETURN_CONST |=> acc == $past(literal) && stack_pop
        && pc_load && pc_value == $past(stack_top) ##1 !stack_pop; endproperty
    a_ret: assert property (p_ret) else $error("return with constant wrong");
    property p_table; go && opcode == `OP_ADD_ACC_PC |=> pc_load
        && pc_value == $past(pc_in) + {3'h0, $past(acc)}; endproperty
    a_table: assert property (p_table) else $error("table jump wrong");
endmodule
bind exec_unit exec_unit_properties chk (.sys_clk(sys_clk), .reset(reset), .issue(issue),
    .dest_file(dest_file), .busy(busy), .file_we(file_we), .pc_load(pc_load),
    .stack_pop(stack_pop), .wdt_clear(wdt_clear), .osc_stop(osc_stop), .opcode(opcode),
    .literal(literal), .file_rdata(file_rdata), .acc(acc), .file_wdata(file_wdata),
    .pc_in(pc_in), .stack_top(stack_top), .pc_value(pc_value), .status(status));

//--- sim/tb_exec_unit.sv
// Directed bench for the execute slice
`timescale 1ns/1ps
module tb_exec_unit;
    reg         sys_clk = 0, reset = 1, issue = 0, dest_file = 0, wake = 0;
    reg  [2:0]  opcode = 0;
    reg  [6:0]  file_addr = 7'h2a;
    reg  [7:0]  literal = 0, file_rdata = 0;
    reg  [10:0] pc_in = 11'h100, stack_top = 11'h123;
    wire [7:0]  acc, file_wdata;
    wire [4:0]  status;
    wire [6:0]  file_waddr;
    wire [10:0] pc_value;
    wire        file_we, pc_load, stack_pop, wdt_clear, osc_stop, busy;
    integer     n_mismatch = 0, compares = 0, i;
    exec_unit dut (.sys_clk(sys_clk), .reset(reset), .issue(issue), .opcode(opcode),
        .file_addr(file_addr), .dest_file(dest_file), .literal(literal),
        .file_rdata(file_rdata), .pc_in(pc_in), .stack_top(stack_top), .wake(wake),
        .acc(acc), .status(status), .file_we(file_we), .file_waddr(file_waddr),
        .file_wdata(file_wdata), .pc_load(pc_load), .pc_value(pc_value),
        .stack_pop(stack_pop), .wdt_clear(wdt_clear), .osc_stop(osc_stop), .busy(busy));
    initial forever #2.5 sys_clk = ~sys_clk;
    task close_out;
        if (n_mismatch == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Drives one issue cycle; outputs are judged just after the taking edge
    task step(input [2:0] op, input d, input [7:0] lit, input [7:0] fr);
        @(posedge sys_clk);
        issue <= 1;
        opcode <= op;
        dest_file <= d;
        literal <= lit;
        file_rdata <= fr;
        @(posedge sys_clk);
        issue <= 0;
        #1;
    endtask
    task t_sub;
        step(3'h3, 1'b0, 8'h00, 8'h00);
        chk({3'h0, acc, status}, 16'h001f);
        step(3'h3, 1'b0, 8'h10, 8'h00);
        chk({3'h0, acc, status}, 16'h021b);
        step(3'h3, 1'b0, 8'h0f, 8'h00);
        chk({3'h0, acc, status}, 16'h1ffa);
    endtask
    task t_rotate;
        step(3'h1, 1'b0, 8'h00, 8'he6);
        chk({3'h0, acc, status}, 16'h0e7a);
        step(3'h1, 1'b1, 8'h00, 8'h01);
        chk({file_we, file_waddr, file_wdata}, 16'haa00);
        chk({3'h0, acc, status}, 16'h0e7b);
        step(3'h2, 1'b0, 8'h00, 8'he6);
        chk({3'h0, acc, status}, 16'h19bb);
        chk({15'h0, file_we}, 16'h0000);
    endtask
    task t_table;
        step(3'h6, 1'b0, 8'h00, 8'h00);
        chk({4'h0, pc_load, pc_value}, 16'h09cd);
        // Unused opcode must leave acc, status and the file_we, pc_load, stack_pop and wdt_clear strobes alone
        step(3'h7, 1'b1, 8'h33, 8'h81);
        chk({3'h0, acc, status}, 16'h19bb);
        chk({12'h0, file_we, pc_load, stack_pop, wdt_clear}, 16'h0000);
    endtask
    task t_return;
        @(posedge sys_clk);
        issue <= 1'b1;
        opcode <= 3'h4;
        literal <= 8'h5a;
        @(posedge sys_clk);
        opcode <= 3'h3;
        #1;
        chk({3'h0, stack_pop, pc_load, pc_value}, 16'h1923);
        chk({8'h0, acc}, 16'h005a);
        @(posedge sys_clk);
        issue <= 1'b0;
        #1;
        chk({7'h0, acc, stack_pop}, 16'h00b4);
    endtask
    task t_sleep;
        step(3'h5, 1'b0, 8'h00, 8'h00);
        chk({9'h0, wdt_clear, osc_stop, status}, 16'h0073);
        step(3'h3, 1'b0, 8'hff, 8'h00);
        chk({6'h0, acc, busy, osc_stop}, 16'h016b);
        @(posedge sys_clk);
        wake <= 1'b1;
        for (i = 0; i < 20 && osc_stop !== 1'b0; i = i + 1) begin
            @(posedge sys_clk);
            #1;
        end
        chk(i[15:0], 16'h0003);
        @(posedge sys_clk);
        wake <= 1'b0;
        step(3'h3, 1'b0, 8'h60, 8'h00);
        chk({3'h0, acc, status}, 16'h00d1);
    endtask
    task t_reset;
        step(3'h5, 1'b0, 8'h00, 8'h00);
        @(posedge sys_clk);
        reset <= 1'b1;
        @(posedge sys_clk);
        @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk({1'b0, osc_stop, busy, acc, status}, 16'h0018);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 0;
        t_sub;
        t_rotate;
        t_table;
        t_return;
        t_sleep;
        t_reset;
        close_out;
    end
endmodule
